/* File: src/osd_pkg.sv */
// Shared constants and types for the octal serial driver control block
package osd_pkg;

   // ---------------------------------------------------------------
   // Sizes and timing
   // ---------------------------------------------------------------
   localparam int CHANS = 8;
   localparam int CLK_NS = 10;
   localparam int BLANK_NS = 160000;
   localparam int BLANK_CYC = BLANK_NS / CLK_NS;
   localparam int BLANK_W = 16;

   typedef logic [BLANK_W-1:0] osd_blank_t;
   typedef logic [CHANS-1:0] osd_chan_t;

   // ---------------------------------------------------------------
   // Values after reset
   // ---------------------------------------------------------------
   localparam osd_chan_t LATCH_RST = 8'h00;
   localparam osd_chan_t SNAP_RST = 8'h00;
   localparam osd_chan_t SHIFT_RST = 8'h00;
   localparam osd_blank_t BLANK_RST = 16'h0000;
   localparam logic SO_RST = 1'b0;
   localparam logic OE_RST = 1'b0;
   localparam logic FLAG_RST = 1'b0;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic
   {
      ST_DESEL = 1'b0,
      ST_SEL = 1'b1
   } osd_sel_e;

   typedef struct packed
   {
      logic fall;
      logic rise;
   } osd_sel_ev_s;

   // Everything that enters the system clock domain through the synchroniser
   typedef struct packed
   {
      logic sel_n;
      logic start;
      logic so_bit;
      osd_chan_t sense;
   } osd_xing_s;

   // Deselected, frame start pending, data low
   localparam osd_xing_s XING_RST = 11'h600;

endpackage

/* File: src/osd_sync.sv */
// Two-stage level synchroniser into the system clock domain
`timescale 1ns/100ps
`default_nettype none

module osd_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
)(
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   // First stage feeds only the second stage
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_r <= RST_VAL;
         q_r <= RST_VAL;
      end
      else
      begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end

   assign q = q_r;

endmodule // osd_sync

`default_nettype wire

/* File: src/osd_ctrl.sv */
// Serial control and fault latch logic of an eight-channel low-side driver
`timescale 1ns/100ps
`default_nettype none

// Function
// - Eight-bit serial command word held internally
// - Per-channel latch bit, common reset clears all
// - Eight diagnostic bits shifted out per transfer
// - Saturation fault clears its own latch bit
// - Shift path chains input through to output
// - Active only while select line is low
// - Serial output released while deselected
// - Select fall loads sensed levels in parallel
// - Select rise copies shift register to latch
// - Next bit presented after each clock rise
// - Command bit sampled on each clock fall
// - Shifting in and out happen together
// - Latch holds and drives outputs until changed
// - Fault clears one bit, others unchanged
// - Reset clears the whole latch at once
// - Enabled channel above threshold is switched off
// - Open off channel reads low through pulldown
// - High output loads one, low loads zero
// - Command one means off, zero means on
// - Channel seven first, channel zero last
// - Fault clearing blanked for delay after rise
// - Shift clock ignored while deselected
module osd_ctrl #(
   parameter int unsigned BLANK_CYC = osd_pkg::BLANK_CYC
)(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic drv_rst_n,
   input wire logic shift_clk,
   input wire logic sel_n,
   input wire logic ser_in,
   input wire logic [osd_pkg::CHANS-1:0] ovr_sense,
   output logic ser_out,
   output logic ser_out_oe,
   output logic [osd_pkg::CHANS-1:0] driver_outputs
);

   localparam osd_pkg::osd_blank_t BLANK_LD =
      osd_pkg::osd_blank_t'(BLANK_CYC);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic frm_start_r;
   osd_pkg::osd_chan_t sr_r;
   osd_pkg::osd_chan_t sr_nxt;
   logic lso_r;
   logic lso_nxt;

   osd_pkg::osd_xing_s xing_raw;
   osd_pkg::osd_xing_s xing_s;
   logic sel_n_d_r;
   osd_pkg::osd_sel_ev_s sel_ev;
   osd_pkg::osd_sel_e sel_st_r;
   osd_pkg::osd_sel_e sel_st_nxt;
   osd_pkg::osd_chan_t snap_r;
   osd_pkg::osd_chan_t snap_nxt;
   logic shifted_r;
   logic shifted_nxt;
   osd_pkg::osd_chan_t word_w;
   osd_pkg::osd_chan_t latch_r;
   osd_pkg::osd_chan_t latch_nxt;
   osd_pkg::osd_chan_t fault_clr;
   osd_pkg::osd_blank_t blank_cnt_r;
   osd_pkg::osd_blank_t blank_cnt_nxt;
   logic blank_done;
   logic so_r;
   logic so_nxt;
   logic oe_r;
   logic oe_nxt;

   // ---------------------------------------------------------------
   // Link domain: shift register on the master's clock
   // ---------------------------------------------------------------
   // The link clock stands still between frames, so the start of a
   // frame is marked by the select line presetting this flag. It is
   // dropped by the first falling shift edge of the frame.
   always_ff @(negedge shift_clk or posedge sel_n)
   begin
      if (sel_n)
         frm_start_r <= 1'b1;
      else
         frm_start_r <= 1'b0;
   end

   // First fall shifts out of the diagnostic snapshot, later falls out
   // of the register itself; bits beyond eight leave unchanged.
   // The snapshot is loaded a few system cycles after select fall, well before any edge.
   assign sr_nxt = frm_start_r ? {snap_r[6:0], ser_in}
                               : {sr_r[6:0], ser_in};

   // Select is steady for the lead and lag times around every edge
   always_ff @(negedge shift_clk or negedge drv_rst_n)
   begin
      if (!drv_rst_n)
         sr_r <= osd_pkg::SHIFT_RST;
      else if (!sel_n)
         sr_r <= sr_nxt;
   end

   // Most significant bit leads: channel seven goes out first
   assign lso_nxt = frm_start_r ? snap_r[7] : sr_r[7];

   always_ff @(posedge shift_clk or negedge drv_rst_n)
   begin
      if (!drv_rst_n)
         lso_r <= osd_pkg::SO_RST;
      else if (!sel_n)
         lso_r <= lso_nxt;
   end

   // ---------------------------------------------------------------
   // Crossing into the system domain
   // ---------------------------------------------------------------
   assign xing_raw.sel_n = sel_n;
   assign xing_raw.start = frm_start_r;
   assign xing_raw.so_bit = lso_r;
   assign xing_raw.sense = ovr_sense;

   osd_sync #(
      .W($bits(osd_pkg::osd_xing_s)),
      .RST_VAL(osd_pkg::XING_RST)
   ) u_sync (
      .clk(sys_clk),
      .rst(sys_rst),
      .d(xing_raw),
      .q(xing_s)
   );

   // ---------------------------------------------------------------
   // Select edges and state
   // ---------------------------------------------------------------
   assign sel_ev.fall = sel_n_d_r & ~xing_s.sel_n;
   assign sel_ev.rise = ~sel_n_d_r & xing_s.sel_n;

   always_comb
   begin
      unique case (sel_st_r)
         osd_pkg::ST_DESEL:
            sel_st_nxt = sel_ev.fall ? osd_pkg::ST_SEL : osd_pkg::ST_DESEL;
         osd_pkg::ST_SEL:
            sel_st_nxt = sel_ev.rise ? osd_pkg::ST_DESEL : osd_pkg::ST_SEL;
      endcase
   end

   // Any falling shift edge seen in this frame means the register,
   // not the snapshot, holds the word to be latched.
   assign shifted_nxt = sel_ev.fall ? 1'b0
                      : (sel_st_r == osd_pkg::ST_SEL && !xing_s.start)
                        ? 1'b1 : shifted_r;

   // ---------------------------------------------------------------
   // Diagnostic snapshot
   // ---------------------------------------------------------------
   // Sense high means the pin sits above threshold; an open pin that
   // is switched off is pulled low and so reads zero.
   assign snap_nxt = sel_ev.fall ? xing_s.sense : snap_r;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         sel_n_d_r <= 1'b1;
         sel_st_r <= osd_pkg::ST_DESEL;
         snap_r <= osd_pkg::SNAP_RST;
         shifted_r <= osd_pkg::FLAG_RST;
      end
      else
      begin
         sel_n_d_r <= xing_s.sel_n;
         sel_st_r <= sel_st_nxt;
         snap_r <= snap_nxt;
         shifted_r <= shifted_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Parallel latch and fault clearing
   // ---------------------------------------------------------------
   // The link register is read only after select has risen and been
   // synchronised; the master keeps its clock still from then on.
   assign word_w = shifted_r ? sr_r : snap_r;

   assign blank_done = (blank_cnt_r == osd_pkg::BLANK_RST);
   assign blank_cnt_nxt = sel_ev.rise ? BLANK_LD
                        : blank_done ? blank_cnt_r
                        : blank_cnt_r - 16'h0001;

   // Latch holds on-bits; a command one switches its channel off
   assign fault_clr = blank_done ? (latch_r & xing_s.sense)
                                 : osd_pkg::LATCH_RST;
   assign latch_nxt = sel_ev.rise ? ~word_w
                    : latch_r & ~fault_clr;

   // Pin reset acts at once; the system reset only on the clock
   always_ff @(posedge sys_clk or negedge drv_rst_n)
   begin
      if (!drv_rst_n)
      begin
         latch_r <= osd_pkg::LATCH_RST;
         blank_cnt_r <= osd_pkg::BLANK_RST;
      end
      else if (sys_rst)
      begin
         latch_r <= osd_pkg::LATCH_RST;
         blank_cnt_r <= osd_pkg::BLANK_RST;
      end
      else
      begin
         latch_r <= latch_nxt;
         blank_cnt_r <= blank_cnt_nxt;
      end
   end

   assign driver_outputs = latch_r;

   // ---------------------------------------------------------------
   // Serial output pin
   // ---------------------------------------------------------------
   // Until the first falling shift edge the leading diagnostic bit
   // stands on the pin; afterwards the link-domain bit is followed.
   assign so_nxt = sel_ev.fall ? xing_s.sense[7]
                 : xing_s.start ? snap_r[7]
                 : xing_s.so_bit;
   assign oe_nxt = ~xing_s.sel_n;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         so_r <= osd_pkg::SO_RST;
         oe_r <= osd_pkg::OE_RST;
      end
      else
      begin
         so_r <= so_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign ser_out = so_r;
   assign ser_out_oe = oe_r;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking ast_cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst || !drv_rst_n);

   sequence s_sel_fall;
      sel_ev.fall;
   endsequence

   sequence s_sel_rise;
      sel_ev.rise;
   endsequence

   sequence s_quiet;
      !sel_ev.rise;
   endsequence

   sequence s_lead;
      sel_st_r == osd_pkg::ST_SEL && xing_s.start;
   endsequence

   sequence s_shift;
      sel_st_r == osd_pkg::ST_SEL && !xing_s.start;
   endsequence

   AST_SNAP_LOAD: assert property (
      s_sel_fall |=> snap_r == $past(xing_s.sense))
      else $error("Snapshot not loaded at select fall");

   AST_FIRST_BIT: assert property (
      s_sel_fall |=> ser_out == $past(xing_s.sense[7]) && ser_out_oe)
      else $error("Channel seven bit not first on output");

   AST_LATCH_COPY: assert property (
      s_sel_rise |=> driver_outputs == ~$past(word_w))
      else $error("Latch not copied at select rise");

   AST_OE_OFF: assert property (
      xing_s.sel_n [*2] |=> !ser_out_oe)
      else $error("Serial output driven while deselected");

   AST_OE_ON: assert property (
      !xing_s.sel_n |=> ser_out_oe)
      else $error("Serial output not driven while selected");

   AST_BLANK_START: assert property (
      s_sel_rise ##1 s_quiet |-> blank_cnt_r == BLANK_LD
         ##1 (blank_cnt_r == BLANK_LD - 16'h0001 || $past(sel_ev.rise)))
      else $error("Blanking delay not started at select rise");

   AST_BLANK_HOLD: assert property (
      !blank_done && !sel_ev.rise |=> driver_outputs == $past(latch_r))
      else $error("Latch changed during blanking");

   AST_FAULT_CLR: assert property (
      blank_done && !sel_ev.rise && (latch_r & xing_s.sense) != 8'h00
         |=> (driver_outputs & $past(xing_s.sense)) == 8'h00)
      else $error("Faulted channel not switched off");

   AST_FAULT_ISO: assert property (
      s_quiet |=> (driver_outputs & ~$past(latch_r)) == 8'h00
         && (($past(latch_r) & ~driver_outputs)
            & ~$past(xing_s.sense)) == 8'h00)
      else $error("Fault touched an unrelated channel");

   AST_PIN_RST: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !drv_rst_n |-> driver_outputs == 8'h00)
      else $error("Latch not cleared by pin reset");

   AST_SO_LEAD: assert property (
      s_lead |=> ser_out == $past(snap_r[7]))
      else $error("Leading diagnostic bit not held before shifting");

   AST_SO_FOLLOW: assert property (
      s_shift |=> ser_out == $past(xing_s.so_bit))
      else $error("Serial output not following the link register");

   AST_OE_STATE: assert property (
      sel_st_r == osd_pkg::ST_SEL |-> ser_out_oe)
      else $error("Serial output off inside a frame");

   AST_BLANK_CNT: assert property (
      !blank_done && !sel_ev.rise
         |=> blank_cnt_r == $past(blank_cnt_r) - 16'h0001)
      else $error("Blanking counter not counting down");

   AST_LATCH_HOLD: assert property (
      !sel_ev.rise && (latch_r & xing_s.sense) == 8'h00
         |=> $stable(driver_outputs))
      else $error("Latch changed with no fault and no select rise");

endmodule // osd_ctrl

`default_nettype wire

/* File: test/osd_master.sv */
// Serial bus master model that frames commands into the driver block
`timescale 1ns/100ps
`default_nettype none

module osd_master (
   output logic sel_n,
   output logic shift_clk,
   output logic ser_in,
   input wire logic so_line
);
   // ---------------------------------------------------------------
   // Idle levels
   // ---------------------------------------------------------------
   initial
   begin
      shift_clk = 1'b0;
      ser_in = 1'b0;
      // Raised after time zero so the frame flag sees a real edge
      #1 sel_n = 1'b1;
   end

   // ---------------------------------------------------------------
   // One frame, 80 ns link clock, clock low at both select edges
   // ---------------------------------------------------------------
   // Reads each bit just before the fall, as the block answers a
   // few system cycles after a rise rather than at once
   task automatic xfer(input logic [15:0] tx, input int n,
      output logic [15:0] rx);
      rx = 16'h0000;
      #3 sel_n = 1'b0;
      #260;
      for (int i = n - 1; i >= 0; i--)
      begin
         ser_in = tx[i];
         #20 shift_clk = 1'b1;
         #39 rx[i] = so_line;
         #1 shift_clk = 1'b0;
         #20;
      end
      #260 sel_n = 1'b1;
      // Released line shows no stale value
      ser_in = ~ser_in;
      #110;
   endtask

   // Clock pulses with the block deselected; they must be ignored
   task automatic idle_clocks(input int n);
      for (int i = 0; i < n; i++)
      begin
         ser_in = ~ser_in;
         #40 shift_clk = 1'b1;
         #40 shift_clk = 1'b0;
      end
      #100;
   endtask
endmodule // osd_master
`default_nettype wire

/* File: test/tb_octal_serial_driver_control.sv */
// Self-checking bench for the octal serial driver control block
`timescale 1ns/100ps
`default_nettype none

module tb_octal_serial_driver_control;
   localparam int unsigned BLANK = 20;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic drv_rst_n = 1'b1;
   logic [osd_pkg::CHANS-1:0] ovr_sense = 8'h00;
   logic [osd_pkg::CHANS-1:0] driver_outputs;
   logic ser_out;
   logic ser_out_oe;
   logic so_last = 1'b0;
   wire sel_n;
   wire shift_clk;
   wire ser_in;
   wire so_line;
   int miscompares = 0;
   int num_checks = 0;

   // ---------------------------------------------------------------
   // Clock, tri-state resolution, instances
   // ---------------------------------------------------------------
   always #5 sys_clk = ~sys_clk;

   always @(posedge sys_clk)
      if (ser_out_oe)
         so_last <= ser_out;
   // Undriven line reads inverted so a stale bit cannot pass
   assign so_line = ser_out_oe ? ser_out : ~so_last;

   osd_ctrl #(.BLANK_CYC(BLANK)) osd_ctrl_i (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .drv_rst_n(drv_rst_n),
      .shift_clk(shift_clk),
      .sel_n(sel_n),
      .ser_in(ser_in),
      .ovr_sense(ovr_sense),
      .ser_out(ser_out),
      .ser_out_oe(ser_out_oe),
      .driver_outputs(driver_outputs)
   );

   osd_master osd_master_i (
      .sel_n(sel_n),
      .shift_clk(shift_clk),
      .ser_in(ser_in),
      .so_line(so_line)
   );

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic complete_run;
      if (miscompares == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_idle;
      cmp8(driver_outputs, 8'h00);
      cmp8({7'h00, ser_out_oe}, 8'h00);
   endtask

   // Sense stays high on on-channels inside the blanking span
   task automatic t_frame;
      logic [15:0] rx;
      ovr_sense = 8'hA5;
      cyc(4);
      osd_master_i.xfer(16'h005A, 8, rx);
      cyc(1);
      cmp8(driver_outputs, 8'hA5);
      ovr_sense = 8'h00;
      cmp8(rx[7:0], 8'hA5);
      cmp8(driver_outputs, 8'hA5);
      cmp8({7'h00, ser_out_oe}, 8'h00);
   endtask

   // Channel 1 is off, so only channel 2 may drop
   task automatic t_fault;
      cyc(BLANK + 4);
      cmp8(driver_outputs, 8'hA5);
      ovr_sense = 8'h06;
      cyc(5);
      cmp8(driver_outputs, 8'hA1);
      ovr_sense = 8'h00;
   endtask

   task automatic t_chain;
      logic [15:0] rx;
      ovr_sense = 8'h3C;
      cyc(4);
      osd_master_i.xfer(16'hC396, 16, rx);
      cyc(1);
      ovr_sense = 8'h00;
      cmp8(rx[15:8], 8'h3C);
      cmp8(rx[7:0], 8'hC3);
      cmp8(driver_outputs, 8'h69);
   endtask

   // Deselected clocks change nothing; an empty frame latches the
   // inverted snapshot
   task automatic t_gate;
      logic [15:0] rx;
      osd_master_i.idle_clocks(4);
      cyc(1);
      cmp8(driver_outputs, 8'h69);
      cmp8({7'h00, ser_out_oe}, 8'h00);
      ovr_sense = 8'h0F;
      cyc(4);
      osd_master_i.xfer(16'h0000, 0, rx);
      cyc(1);
      ovr_sense = 8'h00;
      cmp8(driver_outputs, 8'hF0);
   endtask

   task automatic t_pin_reset;
      cyc(1);
      drv_rst_n = 1'b0;
      #2;
      cmp8(driver_outputs, 8'h00);
      cyc(2);
      drv_rst_n = 1'b1;
      cyc(4);
   endtask

   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial
   begin
      cyc(4);
      sys_rst = 1'b0;
      cyc(4);
      t_idle();
      t_frame();
      t_fault();
      t_chain();
      t_gate();
      t_pin_reset();
      t_frame();
      complete_run();
   end

   initial
   begin
      #300000;
      miscompares++;
      complete_run();
   end
endmodule // tb_octal_serial_driver_control
`default_nettype wire
